// File: logic/decode_params.svh
// Summary of operation
// - Single words are 24 bits; the top 8 bits are the opcode.
// - Double words span 48 bits; the second word's top 8 bits must be zero.
// - A second word that is fetched on its own executes as a no-operation.
// - Every double-word instruction completes in two instruction cycles.
// - Single words take one cycle; condition, PC change or visibility read adds NOP cycles.
// - A taken skip costs two cycles over a single word and three over a double.
// - Double-word moves complete in two instruction cycles.
// - Reads or read-modify-writes of non-CPU SFRs cost one extra cycle; double words add none.
// - File instructions give a file address and a destination of that file or W0.
// - The bit position field is four bits and selects bit 0 to 15.
// - Ten bit immediate: 0 to 255 in byte mode, 0 to 1023 in word mode.
// - The program address immediate always has its lowest bit at zero.
// - Accumulator write-back goes only to W13, directly or post-incremented by two.
// - Square operations use one of W4 to W7 as both multiplicand and multiplier.
// - Multiply operations use one of six distinct pairs from W4 to W7.
// - X prefetch uses W8 or W9 with post-modify, W9 indexed by W12, or none.
// - Y prefetch uses W10 or W11 with post-modify, W11 indexed by W12, or none.
// - X and Y prefetch destinations are W4 to W7 only.
`ifndef DECODE_PARAMS_SVH
`define DECODE_PARAMS_SVH

`define OPC_HI 23
`define OPC_LO 16
`define OPC_NOP 8'h00
`define OPC_CALL_LONG 8'h02
`define OPC_GOTO_LONG 8'h04
`define OPC_MOVE_DBL 8'h08
`define GRP_MISC 4'h0
`define GRP_BRANCH 4'h3
`define GRP_LIT 4'h4
`define GRP_BIT 4'ha
`define GRP_FILE 4'hb
`define GRP_DSP 4'hc
`define GRP_SKIP 4'hd
`define DSP_SQUARE_SEL 2'h1
`define ACC_WB_DIRECT 2'h1
`define ACC_WB_POSTINC 2'h2
`define BYTE_IMM_MAX 10'h0ff
`define W_DEFAULT 4'h0
`define W_DSP_BASE 4'h4
`define W_X_BASE0 4'h8
`define W_X_BASE1 4'h9
`define W_Y_BASE0 4'ha
`define W_Y_BASE1 4'hb
`define W_INDEX 4'hc
`define W_ACC_WB 4'hd
`define PF_INDEXED 4'he
`define PF_NONE 4'hf
`define PF_PER_BASE 4'h7
`define MULT_PAIRS 3'h6
`define EXTRA_BRANCH 3'h3
`define EXTRA_VISIBILITY 3'h1
`define EXTRA_SFR 3'h1

`endif

// File: logic/decode_pkg.sv
package decode_pkg;

  typedef enum logic [3:0] {
    CLS_NOP = 4'h0,
    CLS_DOUBLE = 4'h1,
    CLS_BRANCH = 4'h2,
    CLS_LIT = 4'h3,
    CLS_BIT = 4'h4,
    CLS_FILE = 4'h5,
    CLS_MAC = 4'h6,
    CLS_SQUARE = 4'h7,
    CLS_SKIP = 4'h8,
    CLS_GENERIC = 4'h9
  } instr_class_t;

  typedef struct packed {
    logic enable;
    logic [3:0] base_reg;
    logic indexed;
    logic signed [3:0] modify;
  } prefetch_t;

  typedef struct packed {
    logic enable;
    logic [3:0] dest_reg;
    logic post_inc2;
  } acc_wb_t;

  typedef struct packed {
    logic [12:0] file_addr;
    logic dest_is_file_default_working_reg;
    logic byte_mode;
    logic [3:0] bit_position_field;
    logic [9:0] ten_bit_immediate;
    logic imm_range_err;
    logic [3:0] work_reg;
    logic acc_sel;
    logic [3:0] mult_a;
    logic [3:0] mult_b;
    logic pair_err;
    prefetch_t x_prefetch_addr;
    prefetch_t y_prefetch_addr;
    logic [3:0] x_dest;
    logic [3:0] y_dest;
    acc_wb_t acc_writeback_dest;
  } fields_t;

endpackage

// File: logic/field_if.sv
`timescale 1ns/1ps
`default_nettype none
interface field_if;
  logic [23:0] word;
  decode_pkg::instr_class_t cls;
  decode_pkg::fields_t fields;
  modport extractor (input word, input cls, output fields);
  modport decoder (output word, output cls, input fields);
endinterface
`default_nettype wire

// File: logic/operand_fields.sv
`timescale 1ns/1ps
`default_nettype none
`include "decode_params.svh"
module operand_fields (
  field_if.extractor fb
);

  function automatic decode_pkg::prefetch_t prefetch(input logic [3:0] code,
                                                     input logic [3:0] base0,
                                                     input logic [3:0] base1);
    decode_pkg::prefetch_t p;
    logic [3:0] idx;
    p = '0;
    idx = (code < `PF_PER_BASE) ? code : code - `PF_PER_BASE;
    if (code == `PF_NONE) begin
      p.enable = 1'h0;
    end else if (code == `PF_INDEXED) begin
      p.enable = 1'h1;
      p.base_reg = base1;
      p.indexed = 1'h1;
    end else begin
      p.enable = 1'h1;
      p.base_reg = (code < `PF_PER_BASE) ? base0 : base1;
      unique case (idx)
        4'h0: p.modify = 4'sh6;
        4'h1: p.modify = 4'sh4;
        4'h2: p.modify = 4'sh2;
        4'h3: p.modify = 4'sh0;
        4'h4: p.modify = -4'sh6;
        4'h5: p.modify = -4'sh4;
        default: p.modify = -4'sh2;
      endcase
    end
    return p;
  endfunction

  always_comb begin
    logic [23:0] w;
    decode_pkg::fields_t f;
    w = fb.word;
    f = '0;
    f.work_reg = w[3:0];
    unique case (fb.cls)
      decode_pkg::CLS_FILE: begin
        f.file_addr = w[12:0];
        f.dest_is_file_default_working_reg = ~w[13];
        f.byte_mode = w[14];
      end
      decode_pkg::CLS_BIT, decode_pkg::CLS_SKIP: begin
        // Bit operations address whole words, so the file address is even.
        f.bit_position_field = w[15:12];
        f.file_addr = {w[11:0], 1'h0};
      end
      decode_pkg::CLS_LIT: begin
        f.byte_mode = w[14];
        if (w[14]) begin
          f.ten_bit_immediate = {2'h0, w[11:4]};
          f.imm_range_err = (w[13:4] > `BYTE_IMM_MAX);
        end else begin
          f.ten_bit_immediate = w[13:4];
        end
      end
      decode_pkg::CLS_MAC, decode_pkg::CLS_SQUARE: begin
        f.acc_sel = w[15];
        if (fb.cls == decode_pkg::CLS_SQUARE) begin
          f.mult_a = `W_DSP_BASE + {2'h0, w[13:12]};
          f.mult_b = f.mult_a;
        end else begin
          f.pair_err = (w[14:12] >= `MULT_PAIRS);
          unique case (w[14:12])
            3'h1: begin f.mult_a = 4'h4; f.mult_b = 4'h6; end
            3'h2: begin f.mult_a = 4'h4; f.mult_b = 4'h7; end
            3'h3: begin f.mult_a = 4'h5; f.mult_b = 4'h6; end
            3'h4: begin f.mult_a = 4'h5; f.mult_b = 4'h7; end
            3'h5: begin f.mult_a = 4'h6; f.mult_b = 4'h7; end
            default: begin f.mult_a = 4'h4; f.mult_b = 4'h5; end
          endcase
        end
        f.x_prefetch_addr = prefetch(w[11:8], `W_X_BASE0, `W_X_BASE1);
        f.y_prefetch_addr = prefetch(w[7:4], `W_Y_BASE0, `W_Y_BASE1);
        f.x_dest = `W_DSP_BASE + {2'h0, w[3:2]};
        f.y_dest = `W_DSP_BASE + {2'h0, w[1:0]};
        f.acc_writeback_dest.enable = (w[17:16] == `ACC_WB_DIRECT) ||
                                      (w[17:16] == `ACC_WB_POSTINC);
        f.acc_writeback_dest.dest_reg = `W_ACC_WB;
        f.acc_writeback_dest.post_inc2 = (w[17:16] == `ACC_WB_POSTINC);
      end
      default: begin
        f.work_reg = w[3:0];
      end
    endcase
    fb.fields = f;
  end

endmodule
`default_nettype wire

// File: logic/instr_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "decode_params.svh"
module instr_decode #(
  parameter logic [2:0] BRANCH_EXTRA = `EXTRA_BRANCH,
  parameter logic [2:0] VIS_EXTRA = `EXTRA_VISIBILITY,
  parameter logic [2:0] SFR_EXTRA = `EXTRA_SFR
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [23:0] fetch_word,
  input wire logic fetch_valid,
  output logic fetch_ready,
  input wire logic exec_cond_true,
  input wire logic exec_pc_change,
  input wire logic exec_program_space_visibility,
  input wire logic exec_ext_sfr,
  output logic stall,
  output logic issue_valid,
  output logic issue_nop,
  output logic [7:0] issue_opcode,
  output decode_pkg::instr_class_t issue_class,
  output decode_pkg::fields_t issue_fields,
  output logic [22:0] program_address_immediate,
  output logic second_word_err
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SECOND = 4'h2,
    ST_WAIT = 4'h4,
    ST_SKIP = 4'h8
  } state_t;

  ////////////////////////////////////////////////////////////////////////////////

  function automatic decode_pkg::instr_class_t classify(input logic [7:0] opc);
    decode_pkg::instr_class_t c;
    c = decode_pkg::CLS_GENERIC;
    unique case (opc[7:4])
      `GRP_MISC: begin
        if (opc == `OPC_NOP) begin
          c = decode_pkg::CLS_NOP;
        end else if (opc == `OPC_CALL_LONG || opc == `OPC_GOTO_LONG ||
                     opc == `OPC_MOVE_DBL) begin
          c = decode_pkg::CLS_DOUBLE;
        end
      end
      `GRP_BRANCH: c = decode_pkg::CLS_BRANCH;
      `GRP_LIT: c = decode_pkg::CLS_LIT;
      `GRP_BIT: c = decode_pkg::CLS_BIT;
      `GRP_FILE: c = decode_pkg::CLS_FILE;
      `GRP_DSP: c = (opc[3:2] == `DSP_SQUARE_SEL) ? decode_pkg::CLS_SQUARE : decode_pkg::CLS_MAC;
      `GRP_SKIP: c = decode_pkg::CLS_SKIP;
      default: c = decode_pkg::CLS_GENERIC;
    endcase
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////

  field_if fb ();

  operand_fields u_fields (
    .fb(fb)
  );

  state_t state_q;
  logic [2:0] cnt_q;
  logic skip_pend_q;
  logic skip_second_q;
  logic [14:0] pa_lo_q;
  logic issue_valid_q;
  logic issue_nop_q;
  logic [7:0] issue_opcode_q;
  decode_pkg::instr_class_t issue_class_q;
  decode_pkg::fields_t issue_fields_q;
  logic [22:0] pai_q;
  logic second_err_q;

  decode_pkg::instr_class_t cls;
  logic accept;
  logic is_double;
  logic pc_moves;
  logic skip_take;
  logic [2:0] extra_d;

  assign cls = classify(fetch_word[`OPC_HI:`OPC_LO]);
  assign fb.word = fetch_word;
  assign fb.cls = cls;
  assign fetch_ready = (state_q != ST_WAIT);
  assign stall = (state_q == ST_WAIT);
  assign accept = fetch_valid & fetch_ready;
  assign is_double = (cls == decode_pkg::CLS_DOUBLE);
  assign pc_moves = exec_pc_change | ((cls == decode_pkg::CLS_BRANCH) & exec_cond_true);
  assign skip_take = (cls == decode_pkg::CLS_SKIP) & exec_cond_true;

  // Double words and NOPs never add cycles; the sum saturates nowhere, so the
  // three extras together must stay below eight.
  always_comb begin
    extra_d = 3'h0;
    if (!is_double && cls != decode_pkg::CLS_NOP) begin
      extra_d = (pc_moves ? BRANCH_EXTRA : 3'h0) +
                (exec_program_space_visibility ? VIS_EXTRA : 3'h0) +
                (exec_ext_sfr ? SFR_EXTRA : 3'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (accept) begin
            if (is_double) begin
              state_q <= ST_SECOND;
            end else if (extra_d != 3'h0) begin
              state_q <= ST_WAIT;
            end else if (skip_take) begin
              state_q <= ST_SKIP;
            end
          end
        end
        ST_SECOND: begin
          if (accept) begin
            state_q <= ST_IDLE;
          end
        end
        ST_WAIT: begin
          if (cnt_q == 3'h1) begin
            state_q <= skip_pend_q ? ST_SKIP : ST_IDLE;
          end
        end
        ST_SKIP: begin
          // A skipped double word costs one more discarded fetch.
          if (accept && !(is_double && !skip_second_q)) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 3'h0;
    end else if (state_q == ST_IDLE && accept && !is_double) begin
      cnt_q <= extra_d;
    end else if (state_q == ST_WAIT) begin
      cnt_q <= cnt_q - 3'h1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      skip_pend_q <= 1'h0;
      skip_second_q <= 1'h0;
    end else begin
      if (state_q == ST_IDLE && accept) begin
        skip_pend_q <= skip_take;
      end
      if (state_q == ST_SKIP && accept) begin
        skip_second_q <= is_double && !skip_second_q;
      end else if (state_q != ST_SKIP) begin
        skip_second_q <= 1'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pa_lo_q <= 15'h0000;
      pai_q <= 23'h000000;
      second_err_q <= 1'h0;
    end else begin
      second_err_q <= 1'h0;
      if (state_q == ST_IDLE && accept && is_double) begin
        pa_lo_q <= fetch_word[15:1];
      end
      if (state_q == ST_SECOND && accept) begin
        pai_q <= {fetch_word[6:0], pa_lo_q, 1'h0};
        second_err_q <= (fetch_word[`OPC_HI:`OPC_LO] != `OPC_NOP);
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      issue_valid_q <= 1'h0;
      issue_nop_q <= 1'h0;
      issue_opcode_q <= `OPC_NOP;
      issue_class_q <= decode_pkg::CLS_NOP;
      issue_fields_q <= '0;
    end else begin
      issue_valid_q <= 1'h0;
      issue_nop_q <= 1'h0;
      unique case (state_q)
        ST_IDLE: begin
          if (accept) begin
            issue_opcode_q <= fetch_word[`OPC_HI:`OPC_LO];
            issue_class_q <= cls;
            issue_fields_q <= fb.fields;
            issue_valid_q <= !is_double;
            issue_nop_q <= (cls == decode_pkg::CLS_NOP);
          end
        end
        ST_SECOND: begin
          issue_valid_q <= accept;
        end
        ST_WAIT: begin
          issue_valid_q <= 1'h1;
          issue_nop_q <= 1'h1;
        end
        ST_SKIP: begin
          if (accept) begin
            issue_valid_q <= 1'h1;
            issue_nop_q <= 1'h1;
            issue_opcode_q <= `OPC_NOP;
            issue_class_q <= decode_pkg::CLS_NOP;
          end
        end
      endcase
    end
  end

  assign issue_valid = issue_valid_q;
  assign issue_nop = issue_nop_q;
  assign issue_opcode = issue_opcode_q;
  assign issue_class = issue_class_q;
  assign issue_fields = issue_fields_q;
  assign program_address_immediate = pai_q;
  assign second_word_err = second_err_q;

  ////////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  logic idle_acc;
  assign idle_acc = (state_q == ST_IDLE) && accept;

  opcode_field_a: assert property (
    idle_acc && !is_double |=> issue_valid && issue_opcode == $past(fetch_word[23:16]))
    else $error("opcode not taken from top byte");

  second_zero_a: assert property (
    state_q == ST_SECOND && accept && fetch_word[23:16] != 8'h00 |=> second_word_err)
    else $error("nonzero second word top byte not flagged");

  stray_nop_a: assert property (
    idle_acc && fetch_word[23:16] == 8'h00 |=> issue_valid && issue_nop)
    else $error("lone second word not a nop");

  double_two_a: assert property (
    idle_acc && is_double ##1 fetch_valid |=> issue_valid && !issue_nop && state_q == ST_IDLE)
    else $error("double word not done in two cycles");

  single_one_a: assert property (
    idle_acc && !is_double && extra_d == 3'h0 && !skip_take |=> fetch_ready && issue_valid)
    else $error("plain single word not one cycle");

  branch_nops_a: assert property (
    idle_acc && cls == decode_pkg::CLS_BRANCH && exec_cond_true &&
    !exec_program_space_visibility && !exec_ext_sfr && BRANCH_EXTRA == 3'h3 |=>
    (stall && !issue_nop) ##1 (stall && issue_nop)[*2] ##1 (!stall && issue_nop))
    else $error("taken branch extra cycles wrong");

  sfr_extra_a: assert property (
    idle_acc && !is_double && cls != decode_pkg::CLS_NOP && exec_ext_sfr && !pc_moves &&
    !exec_program_space_visibility && SFR_EXTRA == 3'h1 |=> stall ##1 !stall)
    else $error("sfr access extra cycle wrong");

  stall_hold_a: assert property (
    stall |-> !fetch_ready ##1 $stable(issue_opcode))
    else $error("fetch taken during stall");

  skip_single_a: assert property (
    state_q == ST_SKIP && accept && !is_double |=> state_q == ST_IDLE && issue_nop)
    else $error("single word skip wrong");

  skip_double_a: assert property (
    state_q == ST_SKIP && accept && is_double && !skip_second_q |=> state_q == ST_SKIP)
    else $error("double word skip too short");

  addr_even_a: assert property (
    program_address_immediate[0] == 1'h0)
    else $error("program address lowest bit set");

  byte_imm_a: assert property (
    issue_valid && issue_class == decode_pkg::CLS_LIT && issue_fields.byte_mode |->
    issue_fields.ten_bit_immediate <= 10'h0ff)
    else $error("byte immediate above 255");

  square_pair_a: assert property (
    issue_valid && issue_class == decode_pkg::CLS_SQUARE |->
    issue_fields.mult_a == issue_fields.mult_b && issue_fields.mult_a[3:2] == 2'h1)
    else $error("square operands differ or out of range");

  prefetch_base_a: assert property (
    issue_valid && issue_class == decode_pkg::CLS_MAC && issue_fields.x_prefetch_addr.enable |->
    issue_fields.x_prefetch_addr.base_reg[3:1] == 3'h4 && issue_fields.x_dest[3:2] == 2'h1)
    else $error("x prefetch register out of range");

  file_dest_a: assert property (
    idle_acc && cls == decode_pkg::CLS_FILE |=>
    issue_fields.dest_is_file_default_working_reg == !$past(fetch_word[13]))
    else $error("file destination select wrong");

  bit_field_a: assert property (
    idle_acc && cls == decode_pkg::CLS_BIT |=>
    issue_fields.bit_position_field == $past(fetch_word[15:12]))
    else $error("bit position field wrong");

  word_imm_a: assert property (
    idle_acc && cls == decode_pkg::CLS_LIT && !fetch_word[14] |=>
    issue_fields.ten_bit_immediate == $past(fetch_word[13:4]))
    else $error("word immediate wrong");

  acc_wb_reg_a: assert property (
    issue_valid && issue_fields.acc_writeback_dest.enable |->
    issue_fields.acc_writeback_dest.dest_reg == 4'hd)
    else $error("write-back register not the fixed one");

  mult_pair_a: assert property (
    issue_valid && issue_class == decode_pkg::CLS_MAC |->
    issue_fields.mult_a[3:2] == 2'h1 && issue_fields.mult_b[3:2] == 2'h1 &&
    issue_fields.mult_a < issue_fields.mult_b)
    else $error("multiply pair out of range");

  y_prefetch_a: assert property (
    issue_valid && issue_class == decode_pkg::CLS_MAC &&
    issue_fields.y_prefetch_addr.enable |->
    issue_fields.y_prefetch_addr.base_reg[3:1] == 3'h5 && issue_fields.y_dest[3:2] == 2'h1)
    else $error("y prefetch register out of range");

  move_two_a: assert property (
    idle_acc && fetch_word[23:16] == 8'h08 |=> state_q == ST_SECOND && !issue_valid)
    else $error("double move not held for its second word");

  skip_discard_a: assert property (
    state_q == ST_SKIP && accept |=>
    issue_valid && issue_nop && issue_opcode == 8'h00 && issue_class == decode_pkg::CLS_NOP)
    else $error("skipped word not discarded");

endmodule
`default_nettype wire

// File: logic/dummy_end_marker_not_used.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: verification/fetch_model.sv
`timescale 1ns/1ps
`default_nettype none
module fetch_model (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic fetch_ready,
  output logic [23:0] fetch_word,
  output logic fetch_valid,
  output logic exec_cond_true,
  output logic exec_pc_change,
  output logic exec_program_space_visibility,
  output logic exec_ext_sfr
);
  logic [27:0] q[$];
  logic took;

  task automatic push(input logic [23:0] w, input logic [3:0] f);
    q.push_back({f, w});
  endtask

  function automatic bit busy();
    return fetch_valid || q.size() > 0;
  endfunction

  always @(posedge mclk) begin
    took <= fetch_valid & fetch_ready;
  end

  // A word and its execute flags stay put until taken at a rising edge.
  always @(negedge mclk) begin
    if (!rstn) begin
      fetch_valid <= 1'b0;
      fetch_word <= 24'h000000;
      {exec_cond_true, exec_pc_change, exec_program_space_visibility, exec_ext_sfr} <= 4'h0;
    end else if (!fetch_valid || took) begin
      if (q.size() > 0) begin
        {exec_cond_true, exec_pc_change, exec_program_space_visibility, exec_ext_sfr,
         fetch_word} <= q.pop_front();
        fetch_valid <= 1'b1;
      end else begin
        // Released lines wander so that a stale word is never mistaken for a fresh one.
        fetch_valid <= 1'b0;
        fetch_word <= ~fetch_word;
        {exec_cond_true, exec_pc_change, exec_program_space_visibility, exec_ext_sfr} <= 4'hf;
      end
    end
  end
endmodule
`default_nettype wire

// File: verification/dsp_cpu_instruction_decode_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin \
  compares++; \
  if ((got) !== (exp)) begin \
    err_total++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); \
  end \
end
module dsp_cpu_instruction_decode_tb;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [23:0] fetch_word;
  logic fetch_valid, fetch_ready, cond, pcc, vis, sfr, stall;
  logic issue_valid, issue_nop, second_word_err;
  logic [7:0] issue_opcode;
  decode_pkg::instr_class_t issue_class;
  decode_pkg::fields_t fld;
  logic [22:0] pai;
  int err_total = 0;
  int compares = 0;
  int cycles = 0;
  int n_iss, n_nop, n_stall, n_err;

  always #10 mclk = ~mclk;

  instr_decode i_instr_decode (.mclk(mclk), .rstn(rstn), .fetch_word(fetch_word),
    .fetch_valid(fetch_valid), .fetch_ready(fetch_ready), .exec_cond_true(cond),
    .exec_pc_change(pcc), .exec_program_space_visibility(vis), .exec_ext_sfr(sfr),
    .stall(stall),
    .issue_valid(issue_valid), .issue_nop(issue_nop), .issue_opcode(issue_opcode),
    .issue_class(issue_class), .issue_fields(fld), .program_address_immediate(pai),
    .second_word_err(second_word_err));

  fetch_model i_fetch_model (.mclk(mclk), .rstn(rstn), .fetch_ready(fetch_ready),
    .fetch_word(fetch_word), .fetch_valid(fetch_valid), .exec_cond_true(cond),
    .exec_pc_change(pcc), .exec_program_space_visibility(vis), .exec_ext_sfr(sfr));

  always @(posedge mclk) begin
    if (rstn) begin
      if (issue_valid !== 1'b0) n_iss++;
      if (issue_valid !== 1'b0 && issue_nop !== 1'b0) n_nop++;
      if (stall !== 1'b0) n_stall++;
      if (second_word_err !== 1'b0) n_err++;
    end
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Ceiling is far above the few hundred cycles the tests need.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic run(input logic [23:0] w[$], input logic [3:0] f);
    int k;
    k = 0;
    n_iss = 0;
    n_nop = 0;
    n_stall = 0;
    n_err = 0;
    foreach (w[i]) i_fetch_model.push(w[i], (i == 0) ? f : 4'h0);
    @(posedge mclk);
    while (i_fetch_model.busy() && k < 100) begin
      @(posedge mclk);
      k++;
    end
    repeat (8) @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic cnt(input int iss, input int nop, input int stl);
    `CHK("issues", iss, n_iss)
    `CHK("nops", nop, n_nop)
    `CHK("stalls", stl, n_stall)
  endtask

  task automatic t_literal();
    run('{24'h4052c3}, 4'h0);
    cnt(1, 0, 0);
    `CHK("opcode", 8'h40, issue_opcode)
    `CHK("class", decode_pkg::CLS_LIT, issue_class)
    `CHK("byte imm", 10'h02c, fld.ten_bit_immediate)
    `CHK("byte range", 1'b1, fld.imm_range_err)
    `CHK("work reg", 4'h3, fld.work_reg)
    run('{24'h403ff3}, 4'h0);
    `CHK("word imm", 10'h3ff, fld.ten_bit_immediate)
    `CHK("word range", 1'b0, fld.imm_range_err)
    $display("literal test done");
  endtask

  task automatic t_extra();
    run('{24'h300000, 24'h41ffff}, 4'h8);
    cnt(5, 3, 3);
    `CHK("held word", 8'h41, issue_opcode)
    run('{24'h400000}, 4'h1);
    cnt(2, 1, 1);
    run('{24'h400000}, 4'h3);
    cnt(3, 2, 2);
    run('{24'h400000}, 4'h7);
    cnt(6, 5, 5);
    $display("extra cycle test done");
  endtask

  task automatic t_double();
    run('{24'h02abcd, 24'h000055}, 4'h0);
    cnt(1, 0, 0);
    `CHK("address", {7'h55, 15'h55e6, 1'b0}, pai)
    `CHK("address lsb", 1'b0, pai[0])
    `CHK("good second", 0, n_err)
    run('{24'h081235, 24'h00007f}, 4'h7);
    cnt(1, 0, 0);
    `CHK("move class", decode_pkg::CLS_DOUBLE, issue_class)
    run('{24'h04ffff, 24'h120001}, 4'h0);
    `CHK("bad second", 1, n_err)
    run('{24'h001234}, 4'h0);
    cnt(1, 1, 0);
    $display("double word test done");
  endtask

  task automatic t_skip();
    run('{24'hd00000, 24'h401111}, 4'h8);
    cnt(2, 1, 0);
    run('{24'hd00000, 24'h020002, 24'h000001, 24'h405555}, 4'h8);
    cnt(4, 2, 0);
    `CHK("after skip", 8'h40, issue_opcode)
    $display("skip test done");
  endtask

  task automatic t_file();
    run('{24'hb07abc}, 4'h0);
    `CHK("file addr", 13'h1abc, fld.file_addr)
    `CHK("dest file", 1'b0, fld.dest_is_file_default_working_reg)
    `CHK("byte", 1'b1, fld.byte_mode)
    run('{24'hb01abc}, 4'h0);
    `CHK("dest w0", 1'b1, fld.dest_is_file_default_working_reg)
    run('{24'ha0f123}, 4'h0);
    `CHK("bit pos", 4'hf, fld.bit_position_field)
    `CHK("bit addr", 13'h0246, fld.file_addr)
    $display("file and bit test done");
  endtask

  task automatic t_dsp();
    logic [3:0] pa[7] = '{4'h4, 4'h4, 4'h4, 4'h5, 4'h5, 4'h6, 4'h4};
    logic [3:0] pb[7] = '{4'h5, 4'h6, 4'h7, 4'h6, 4'h7, 4'h7, 4'h5};
    run('{24'hc1a7ed}, 4'h0);
    `CHK("x prefetch", {1'b1, 4'h9, 1'b0, 4'h6}, fld.x_prefetch_addr)
    `CHK("y base", 4'hb, fld.y_prefetch_addr.base_reg)
    `CHK("y indexed", 1'b1, fld.y_prefetch_addr.indexed)
    `CHK("x dest", 4'h7, fld.x_dest)
    `CHK("y dest", 4'h5, fld.y_dest)
    `CHK("writeback", {1'b1, 4'hd, 1'b0}, fld.acc_writeback_dest)
    `CHK("acc", 1'b1, fld.acc_sel)
    run('{24'hc62ff0}, 4'h0);
    `CHK("square class", decode_pkg::CLS_SQUARE, issue_class)
    `CHK("square a", 4'h6, fld.mult_a)
    `CHK("square b", 4'h6, fld.mult_b)
    `CHK("no x", 1'b0, fld.x_prefetch_addr.enable)
    `CHK("no y", 1'b0, fld.y_prefetch_addr.enable)
    `CHK("postinc", {1'b1, 4'hd, 1'b1}, fld.acc_writeback_dest)
    for (int p = 0; p < 7; p++) begin
      run('{{8'hc0, 1'b0, 3'(p), 12'hfff}}, 4'h0);
      `CHK("pair a", pa[p], fld.mult_a)
      `CHK("pair b", pb[p], fld.mult_b)
      `CHK("pair err", (p == 6), fld.pair_err)
    end
    $display("dsp test done");
  endtask

  initial begin
    repeat (6) @(negedge mclk);
    rstn = 1'b1;
    @(negedge mclk);
    `CHK("idle ready", 1'b1, fetch_ready)
    t_literal();
    t_extra();
    t_double();
    t_skip();
    t_file();
    t_dsp();
    report_and_stop();
  end
endmodule
`default_nettype wire
